// File: common/eeiu_regs.svh
// register indices, reset values and bus answers of the edge interrupt unit
`ifndef EEIU_REGS_SVH
`define EEIU_REGS_SVH
`define EEIU_IDX_FLG_LO 6'h06
`define EEIU_IDX_FLG_HI 6'h07
`define EEIU_IDX_EN_LO 6'h08
`define EEIU_IDX_EN_HI 6'h09
`define EEIU_IDX_SEL_LO 6'h0c
`define EEIU_IDX_SEL_HI 6'h0d
`define EEIU_IDX_IRQ_ST 6'h10
`define EEIU_IDX_IRQ_CLR 6'h11
`define EEIU_IDX_IRQ_EN 6'h12
`define EEIU_RST_LINES 16'h0000
`define EEIU_RESP_OKAY 2'h0
`define EEIU_RESP_SLVERR 2'h2
`define EEIU_ARM_DONE 2'h3
`endif

// File: common/eeiu_pkg.sv
// state types of the edge interrupt unit
package eeiu_pkg;
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic [1:0] arm;
	} eeiu_edge_s;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} eeiu_axil_s;

	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] en;
		logic [15:0] sel;
		logic [15:0] st;
		logic [15:0] ie;
		logic [15:0] req;
		logic irq;
	} eeiu_top_s;
endpackage

// File: logic/eeiu_edge.sv
// pin synchroniser and edge detector for one interrupt line
`timescale 1ns/100ps
`include "eeiu_regs.svh"
module eeiu_edge
	import eeiu_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin,
	input wire logic falling,
	output logic hit
);
	eeiu_edge_s q;
	eeiu_edge_s d;

	always_comb begin
		d = q;
		d.s1 = pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// no edges until the chain holds real pin samples
		if (q.arm != `EEIU_ARM_DONE) begin
			d.arm = q.arm + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign hit = (q.arm == `EEIU_ARM_DONE) &&
		(falling ? (q.s3 & ~q.s2) : (~q.s3 & q.s2));

	pol_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
		hit |-> ($past(pin, 2) == !falling) && ($past(pin, 3) == falling))
		else $error("edge reported against selected polarity");
endmodule

// File: logic/eeiu_axil.sv
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/100ps
`include "eeiu_regs.svh"
module eeiu_axil
	import eeiu_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output logic [5:0] wr_idx,
	output logic [7:0] wr_data,
	output logic wr_lane,
	input wire logic wr_ok,
	output logic rd_en,
	output logic [5:0] rd_idx,
	input wire logic [7:0] rd_data,
	input wire logic rd_ok
);
	eeiu_axil_s q;
	eeiu_axil_s d;

	assign wr_en = q.aw_got & q.w_got & ~q.bvalid;
	assign wr_idx = q.addr[7:2];
	assign wr_data = q.wdata[7:0];
	assign wr_lane = q.wstrb[0];
	assign rd_en = arvalid & q.arready;
	assign rd_idx = araddr[7:2];

	always_comb begin
		d = q;
		if (awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.addr = awaddr;
		end
		if (wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = wdata;
			d.wstrb = wstrb;
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_en) begin
			d.bvalid = 1'b1;
			d.bresp = wr_ok ? `EEIU_RESP_OKAY : `EEIU_RESP_SLVERR;
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
		end
		// no new address or data while the answer is still pending
		d.awready = ~d.aw_got & ~d.bvalid;
		d.wready = ~d.w_got & ~d.bvalid;
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
		if (rd_en) begin
			d.rvalid = 1'b1;
			d.rdata = {24'h000000, rd_data};
			d.rresp = rd_ok ? `EEIU_RESP_OKAY : `EEIU_RESP_SLVERR;
		end
		d.arready = ~d.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign awready = q.awready;
	assign wready = q.wready;
	assign bresp = q.bresp;
	assign bvalid = q.bvalid;
	assign arready = q.arready;
	assign rdata = q.rdata;
	assign rresp = q.rresp;
	assign rvalid = q.rvalid;
endmodule

// File: logic/eeiu_top.sv
// sixteen-line external edge interrupt unit with axi4-lite registers
`timescale 1ns/100ps
`include "eeiu_regs.svh"
// Behaviour
// - selected pin edge sets its flag; lines 0-7, 8-15 in two registers
// - a set flag stays until software writes zero or reset
// - a flag at one, from pin or software, raises its line request if its enable bit is one
// - enable bit one lets the line request through, zero blocks it
// - edge-select zero picks rising edges, one picks falling edges
// - bit n of low register is line n, of high register line n+8
module eeiu_top
	import eeiu_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] ext_irq_pin,
	output logic [15:0] line_req,
	output logic irq
);
	eeiu_top_s q;
	eeiu_top_s d;
	logic [15:0] edge_v;
	logic wr_en;
	logic [5:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_lane;
	logic wr_ok;
	logic rd_en;
	logic [5:0] rd_idx;
	logic [7:0] rd_data;
	logic rd_ok;
	logic wl;
	logic [15:0] clr_v;

	eeiu_axil u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(s_axi_awaddr),
		.awvalid(s_axi_awvalid),
		.awready(s_axi_awready),
		.wdata(s_axi_wdata),
		.wstrb(s_axi_wstrb),
		.wvalid(s_axi_wvalid),
		.wready(s_axi_wready),
		.bresp(s_axi_bresp),
		.bvalid(s_axi_bvalid),
		.bready(s_axi_bready),
		.araddr(s_axi_araddr),
		.arvalid(s_axi_arvalid),
		.arready(s_axi_arready),
		.rdata(s_axi_rdata),
		.rresp(s_axi_rresp),
		.rvalid(s_axi_rvalid),
		.rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_lane(wr_lane),
		.wr_ok(wr_ok),
		.rd_en(rd_en),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	for (genvar i = 0; i < 16; i++) begin : g_line
		eeiu_edge u_edge (
			.aclk(aclk),
			.aresetn(aresetn),
			.pin(ext_irq_pin[i]),
			.falling(q.sel[i]),
			.hit(edge_v[i])
		);
	end

	// read decode; write-only clear register reads as zero
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 8'h00;
		if (rd_idx == `EEIU_IDX_FLG_LO) begin
			rd_data = q.flags[7:0];
		end else if (rd_idx == `EEIU_IDX_FLG_HI) begin
			rd_data = q.flags[15:8];
		end else if (rd_idx == `EEIU_IDX_EN_LO) begin
			rd_data = q.en[7:0];
		end else if (rd_idx == `EEIU_IDX_EN_HI) begin
			rd_data = q.en[15:8];
		end else if (rd_idx == `EEIU_IDX_SEL_LO) begin
			rd_data = q.sel[7:0];
		end else if (rd_idx == `EEIU_IDX_SEL_HI) begin
			rd_data = q.sel[15:8];
		end else if (rd_idx == `EEIU_IDX_IRQ_ST) begin
			rd_data = q.st[7:0];
		end else if (rd_idx == `EEIU_IDX_IRQ_EN) begin
			rd_data = q.ie[7:0];
		end else if (rd_idx == `EEIU_IDX_IRQ_CLR) begin
			rd_data = 8'h00;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// status register is read-only, so writes to it are refused
	always_comb begin
		wr_ok = 1'b1;
		if (wr_idx == `EEIU_IDX_FLG_LO || wr_idx == `EEIU_IDX_FLG_HI) begin
			wr_ok = 1'b1;
		end else if (wr_idx == `EEIU_IDX_EN_LO || wr_idx == `EEIU_IDX_EN_HI) begin
			wr_ok = 1'b1;
		end else if (wr_idx == `EEIU_IDX_SEL_LO ||
			wr_idx == `EEIU_IDX_SEL_HI) begin
			wr_ok = 1'b1;
		end else if (wr_idx == `EEIU_IDX_IRQ_CLR ||
			wr_idx == `EEIU_IDX_IRQ_EN) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	assign wl = wr_en & wr_lane;

	always_comb begin
		d = q;
		clr_v = 16'h0000;
		if (wl && wr_idx == `EEIU_IDX_FLG_LO) begin
			d.flags[7:0] = wr_data;
		end else if (wl && wr_idx == `EEIU_IDX_FLG_HI) begin
			d.flags[15:8] = wr_data;
		end else if (wl && wr_idx == `EEIU_IDX_EN_LO) begin
			d.en[7:0] = wr_data;
		end else if (wl && wr_idx == `EEIU_IDX_EN_HI) begin
			d.en[15:8] = wr_data;
		end else if (wl && wr_idx == `EEIU_IDX_SEL_LO) begin
			d.sel[7:0] = wr_data;
		end else if (wl && wr_idx == `EEIU_IDX_SEL_HI) begin
			d.sel[15:8] = wr_data;
		end else if (wl && wr_idx == `EEIU_IDX_IRQ_CLR) begin
			clr_v = {8'h00, wr_data};
		end else if (wl && wr_idx == `EEIU_IDX_IRQ_EN) begin
			d.ie = {8'h00, wr_data};
		end
		// a pin edge beats a software zero in the same cycle
		d.flags = d.flags | edge_v;
		d.req = q.flags & q.en;
		// status bit 0: some enabled line requests; stays until a clear write made when none does
		d.st = (q.st & ~clr_v) | {15'h0000, |q.req};
		d.irq = |(q.st & q.ie);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign line_req = q.req;
	assign irq = q.irq;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	flag_set_a: assert property ((edge_v != 16'h0000) |=>
		((q.flags & $past(edge_v)) == $past(edge_v)))
		else $error("pin edge did not set its flag");

	flag_hold_a: assert property (((~q.flags & $past(q.flags)) != 16'h0000)
		|-> $past(wl && (wr_idx == `EEIU_IDX_FLG_LO ||
		wr_idx == `EEIU_IDX_FLG_HI)))
		else $error("flag cleared without a software write");

	req_follow_a: assert property (1'b1 |=>
		(q.req == $past(q.flags & q.en)))
		else $error("line request does not follow flag and enable");

	// per line, so a flag waiting on a disabled line is really exercised
	en_gate_a: assert property (((q.flags & ~q.en) != 16'h0000) |=>
		((q.req & ~$past(q.en)) == 16'h0000))
		else $error("disabled line raised a request");

	hi_map_a: assert property ((wl && wr_idx == `EEIU_IDX_EN_HI) |=>
		(q.en[15:8] == $past(wr_data)) && $stable(q.en[7:0]))
		else $error("high enable write landed on wrong lines");

	reset_clear_a: assert property ($rose(aresetn) |->
		(q.flags == `EEIU_RST_LINES) && (q.en == `EEIU_RST_LINES) &&
		(q.sel == `EEIU_RST_LINES))
		else $error("reset left a line bit set");

	irq_out_a: assert property (((q.st & q.ie) != 16'h0000) |=> irq)
		else $error("enabled status did not raise the interrupt");
endmodule

// File: sim/eeiu_pin_src.sv
// external pin source model driving the sixteen interrupt lines
`timescale 1ns/100ps
module eeiu_pin_src (
	input wire logic aclk,
	output logic [15:0] pins
);
	initial pins = 16'h0000;
	// levels move just after an edge so the synchroniser sees clean steps
	task automatic drive(input logic [15:0] v);
		@(posedge aclk);
		pins <= v;
	endtask
endmodule

// File: sim/eeiu_top_tb.sv
// self-checking bench of the edge interrupt unit
`timescale 1ns/100ps
`include "eeiu_regs.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
	$display("[FAIL] %s exp %h got %h", n, e, a); bad_count++; end end
module eeiu_top_tb
	import eeiu_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [3:0] strb = 4'h1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, r;
	logic [15:0] pins, line_req;
	int bad_count = 0, samples_checked = 0;
	always #10 aclk = ~aclk;
	eeiu_pin_src i_src (.aclk(aclk), .pins(pins));
	eeiu_top i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_irq_pin(pins), .line_req(line_req), .irq(irq));
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [5:0] i, input logic [7:0] d);
		logic a, w;
		a = 1'b1;
		w = 1'b1;
		@(posedge aclk);
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (a || w) begin
			@(posedge aclk);
			if (a && awready) begin
				a = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] i, input logic [7:0] e);
		@(posedge aclk);
		araddr <= {i, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		r = rresp;
		`CHK("rdata", {24'h0, e}, rdata)
	endtask
	task automatic t_reset();
		logic [5:0] ix[6] = '{`EEIU_IDX_FLG_LO, `EEIU_IDX_FLG_HI,
			`EEIU_IDX_EN_LO, `EEIU_IDX_EN_HI, `EEIU_IDX_SEL_LO, `EEIU_IDX_SEL_HI};
		foreach (ix[k]) rd(ix[k], 8'h00);
		`CHK("rresp", `EEIU_RESP_OKAY, r)
	endtask
	task automatic t_rise();
		wr(`EEIU_IDX_EN_LO, 8'h08);
		wr(`EEIU_IDX_EN_HI, 8'h80);
		`CHK("bresp", `EEIU_RESP_OKAY, r)
		i_src.drive(16'h8008);
		wt(8);
		`CHK("line_req", 16'h8008, line_req)
		i_src.drive(16'h0000);
		wt(8);
		rd(`EEIU_IDX_FLG_LO, 8'h08);
		rd(`EEIU_IDX_FLG_HI, 8'h80);
		`CHK("line_req", 16'h8008, line_req)
	endtask
	task automatic t_fall();
		wr(`EEIU_IDX_FLG_HI, 8'h00);
		wr(`EEIU_IDX_SEL_HI, 8'h01);
		wr(`EEIU_IDX_EN_HI, 8'h01);
		i_src.drive(16'h0100);
		wt(8);
		rd(`EEIU_IDX_FLG_HI, 8'h00);
		i_src.drive(16'h0000);
		wt(8);
		rd(`EEIU_IDX_FLG_HI, 8'h01);
		rd(`EEIU_IDX_SEL_HI, 8'h01);
	endtask
	task automatic t_mask();
		wr(`EEIU_IDX_EN_LO, 8'h00);
		wr(`EEIU_IDX_FLG_LO, 8'h20);
		wt(4);
		`CHK("line_req", 16'h0100, line_req)
		wr(`EEIU_IDX_EN_LO, 8'h20);
		wt(4);
		`CHK("line_req", 16'h0120, line_req)
		// lane 0 off: accepted but must leave the enables alone
		strb = 4'h0;
		wr(`EEIU_IDX_EN_LO, 8'hff);
		strb = 4'h1;
		`CHK("bresp", `EEIU_RESP_OKAY, r)
		rd(`EEIU_IDX_EN_LO, 8'h20);
	endtask
	task automatic t_irq();
		// status re-sets while any request stands, so drop them first
		wr(`EEIU_IDX_IRQ_EN, 8'h01);
		wt(6);
		`CHK("irq", 1'b1, irq)
		rd(`EEIU_IDX_IRQ_ST, 8'h01);
		wr(`EEIU_IDX_FLG_LO, 8'h00);
		wr(`EEIU_IDX_FLG_HI, 8'h00);
		wr(`EEIU_IDX_IRQ_CLR, 8'h01);
		wt(6);
		`CHK("irq", 1'b0, irq)
		`CHK("line_req", 16'h0000, line_req)
		wr(`EEIU_IDX_IRQ_ST, 8'h01);
		`CHK("bresp", `EEIU_RESP_SLVERR, r)
		rd(6'h3f, 8'h00);
		`CHK("rresp", `EEIU_RESP_SLVERR, r)
	endtask
	task automatic t_rst2();
		wr(`EEIU_IDX_FLG_HI, 8'h40);
		wr(`EEIU_IDX_SEL_LO, 8'h04);
		@(posedge aclk);
		aresetn <= 1'b0;
		wt(2);
		aresetn <= 1'b1;
		`CHK("line_req", 16'h0000, line_req)
		`CHK("irq", 1'b0, irq)
		t_reset();
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#100000;
		bad_count++;
		end_of_test();
	end
	initial begin
		wt(2);
		aresetn <= 1'b1;
		t_reset();
		t_rise();
		t_fall();
		t_mask();
		t_irq();
		t_rst2();
		end_of_test();
	end
endmodule
